// ### rtl/quad_counter_consts.vh
`ifndef QUAD_COUNTER_CONSTS_VH
`define QUAD_COUNTER_CONSTS_VH

// Accumulator and preset width.
`define ACC_W        16
// Output pattern and mask width.
`define OUT_W        16
// Filter delay field width, in enable ticks.
`define FILT_W       8
// Filter tick period in nanoseconds and the clock period.
`define TICK_NS      1000
`define CLK_NS       8
`define ACC_ZERO     16'h0000
`define ACC_ONE      16'h0001
`define FILT_ZERO    8'h00

`endif

// ### rtl/input_filter.v
`include "quad_counter_consts.vh"

// Passes a level through only after it has held for the set number of ticks.
module input_filter
(
    // Clock and reset
    input  wire                core_clk_i,
    input  wire                rst_i,
    // Filter timing
    input  wire                tick_i,
    input  wire [`FILT_W-1:0]  delay_i,
    // Signal
    input  wire                raw_i,
    output reg                 clean_o
);

    reg [`FILT_W-1:0] cnt_q;

    always @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_q   <= `FILT_ZERO;
            clean_o <= 1'b0;
        end
        else if (raw_i == clean_o)
        begin
            cnt_q <= `FILT_ZERO;
        end
        else if (cnt_q >= delay_i)
        begin
            clean_o <= raw_i;
            cnt_q   <= `FILT_ZERO;
        end
        else if (tick_i)
        begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

endmodule // input_filter

// ### rtl/quadrature_preset_counter.v
`include "quad_counter_consts.vh"

// What this block does
// R1: Count up or down from A/B phase.
// R2: Zero accumulator on reset input or command.
// R3: Hold input suspends counting.
// R4: Reaching high preset drives high pattern.
// R5: Reaching low preset drives low pattern.
// R6: Interrupt only on transition onto preset.
// R7: Low preset hit flag records cause.
// R8: High preset hit flag recorded separately.
// R9: Program may force low interrupt via 1-then-0.
// R10: Program loads parameters, mask, then enables.
// R11: Program writes parameters on first scan.
// R12: Adjustable filters on A, B, reset, hold.
// R13: Presets relative to last reset zero point.
// R14: Patterns drive only mask-selected outputs.
// R15: Counter disabled each run entry until enabled.
// R16: Acknowledge clears each preset hit flag.
module quadrature_preset_counter
#(
    parameter TICK_CYC = (`TICK_NS + `CLK_NS - 1) / `CLK_NS
)
(
    // Clock and reset
    input  wire                core_clk_i,
    input  wire                rst_i,
    // Encoder side
    input  wire                enc_a_i,
    input  wire                enc_b_i,
    input  wire                ext_reset_i,
    input  wire                ext_hold_i,
    // Filter delays in ticks
    input  wire [`FILT_W-1:0]  filt_a_i,
    input  wire [`FILT_W-1:0]  filt_b_i,
    input  wire [`FILT_W-1:0]  filt_rst_i,
    input  wire [`FILT_W-1:0]  filt_hold_i,
    // Program control
    input  wire                run_entry_i,
    input  wire                enable_instr_i,
    input  wire                load_outputs_instr_i,
    input  wire                clear_instr_i,
    input  wire                acc_write_instr_i,
    input  wire [`ACC_W-1:0]   acc_write_val_i,
    input  wire                ack_low_i,
    input  wire                ack_high_i,
    // Parameters
    input  wire [`ACC_W-1:0]   high_preset_i,
    input  wire [`ACC_W-1:0]   low_preset_i,
    input  wire [`OUT_W-1:0]   out_mask_i,
    input  wire [`OUT_W-1:0]   high_pattern_i,
    input  wire [`OUT_W-1:0]   low_pattern_i,
    input  wire [`OUT_W-1:0]   prog_out_i,
    // Status and outputs
    output reg  [`ACC_W-1:0]   acc_o,
    output reg                 enabled_o,
    output reg                 low_preset_hit_flag_o,
    output reg                 high_preset_hit_flag_o,
    output reg                 irq_o,
    output reg  [`OUT_W-1:0]   out_o
);

    localparam TC_W = 16;
    localparam integer    TICK_LAST_I = TICK_CYC - 1;
    localparam [TC_W-1:0] TICK_LAST   = TICK_LAST_I[TC_W-1:0];

    reg  [TC_W-1:0]    tick_cnt_q;
    reg                tick_q;
    reg                a_q;
    reg                b_q;
    reg  [`OUT_W-1:0]  mask_q;
    reg  [`OUT_W-1:0]  hpat_q;
    reg  [`OUT_W-1:0]  lpat_q;
    reg  [`OUT_W-1:0]  hw_out_q;
    reg  [`ACC_W-1:0]  acc_d;
    reg                step_up;
    reg                step_dn;
    wire [`ACC_W-1:0]  acc_q;
    wire               a_f;
    wire               b_f;
    wire               rst_f;
    wire               hold_f;

    assign acc_q = acc_o;

    // Divider giving the filter time base.
    always @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tick_cnt_q <= {TC_W{1'b0}};
            tick_q     <= 1'b0;
        end
        else if (tick_cnt_q == TICK_LAST)
        begin
            tick_cnt_q <= {TC_W{1'b0}};
            tick_q     <= 1'b1;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
            tick_q     <= 1'b0;
        end
    end

    input_filter u_filt_a (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .tick_i     (tick_q),
        .delay_i    (filt_a_i),
        .raw_i      (enc_a_i),
        .clean_o    (a_f)
    ); // R12
    input_filter u_filt_b (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .tick_i     (tick_q),
        .delay_i    (filt_b_i),
        .raw_i      (enc_b_i),
        .clean_o    (b_f)
    ); // R12
    input_filter u_filt_r (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .tick_i     (tick_q),
        .delay_i    (filt_rst_i),
        .raw_i      (ext_reset_i),
        .clean_o    (rst_f)
    ); // R12
    input_filter u_filt_h (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .tick_i     (tick_q),
        .delay_i    (filt_hold_i),
        .raw_i      (ext_hold_i),
        .clean_o    (hold_f)
    ); // R12

    // Full x4 quadrature decode and next accumulator value.
    always @*
    begin
        step_up = 1'b0;
        step_dn = 1'b0;
        if ((a_f != a_q) ^ (b_f != b_q))
        begin
            step_up = (a_f ^ b_q);                           // R1
            step_dn = ~(a_f ^ b_q);                          // R1
        end
        acc_d = acc_q;
        if (clear_instr_i || rst_f)
            acc_d = `ACC_ZERO;                               // R2 R13
        else if (acc_write_instr_i)
            acc_d = acc_write_val_i;
        else if (enabled_o && !hold_f && step_up)            // R3
            acc_d = acc_q + `ACC_ONE;
        else if (enabled_o && !hold_f && step_dn)
            acc_d = acc_q - `ACC_ONE;
    end

    always @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            a_q                    <= 1'b0;
            b_q                    <= 1'b0;
            acc_o                  <= `ACC_ZERO;
            enabled_o              <= 1'b0;
            low_preset_hit_flag_o  <= 1'b0;
            high_preset_hit_flag_o <= 1'b0;
            irq_o                  <= 1'b0;
            mask_q                 <= {`OUT_W{1'b0}};
            hpat_q                 <= {`OUT_W{1'b0}};
            lpat_q                 <= {`OUT_W{1'b0}};
            hw_out_q               <= {`OUT_W{1'b0}};
            out_o                  <= {`OUT_W{1'b0}};
        end
        else
        begin
            a_q      <= a_f;
            b_q      <= b_f;
            acc_o    <= acc_d;
            if (run_entry_i)
                enabled_o <= 1'b0;                           // R15
            else if (enable_instr_i)
                enabled_o <= 1'b1;                           // R15
            if (load_outputs_instr_i)
            begin
                mask_q <= out_mask_i;
                hpat_q <= high_pattern_i;
                lpat_q <= low_pattern_i;
            end
            // Hits count only when the value changes onto a preset; set wins.
            if (acc_d != acc_q && acc_d == high_preset_i)    // R6
            begin
                high_preset_hit_flag_o <= 1'b1;              // R8
                hw_out_q               <= hpat_q;            // R4
            end
            else if (ack_high_i)
                high_preset_hit_flag_o <= 1'b0;              // R16
            if (acc_d != acc_q && acc_d == low_preset_i)     // R6
            begin
                low_preset_hit_flag_o <= 1'b1;               // R7
                hw_out_q              <= lpat_q;             // R5
            end
            else if (ack_low_i)
                low_preset_hit_flag_o <= 1'b0;               // R16
            irq_o <= low_preset_hit_flag_o | high_preset_hit_flag_o;
            out_o <= (hw_out_q & mask_q) | (prog_out_i & ~mask_q); // R14
        end
    end

endmodule // quadrature_preset_counter

// ### dv/quad_encoder_model.sv
module quad_encoder_model (
    // Clock
    input  logic core_clk_i,
    // Encoder channels and switch line
    output logic enc_a_o,
    output logic enc_b_o,
    output logic sw_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph = 2'h0;
    logic       sw = 1'b0;
    // Gray phase count, so A leads B when moving forward.
    assign enc_a_o = ph[0] ^ ph[1];
    assign enc_b_o = ph[1];
    assign sw_o    = sw;
    task step(input logic up);
        @(posedge core_clk_i);
        #1 ph = up ? ph + 2'h1 : ph - 2'h1;
        repeat (12) @(posedge core_clk_i);
        #1;
    endtask
    task set_sw(input logic v);
        @(posedge core_clk_i);
        #1 sw = v;
        repeat (12) @(posedge core_clk_i);
        #1;
    endtask
endmodule // quad_encoder_model

// ### dv/qpc_checker.sv
`include "quad_counter_consts.vh"
module qpc_checker (
    // Clock, reset and program control
    input logic             core_clk_i,
    input logic             rst_i,
    input logic             run_entry_i,
    input logic             enable_instr_i,
    input logic             clear_instr_i,
    input logic             acc_write_instr_i,
    input logic             ack_low_i,
    input logic             ack_high_i,
    input logic [`ACC_W-1:0] acc_write_val_i,
    input logic [`ACC_W-1:0] low_preset_i,
    input logic [`ACC_W-1:0] high_preset_i,
    // Status
    input logic [`ACC_W-1:0] acc_o,
    input logic             enabled_o,
    input logic             low_preset_hit_flag_o,
    input logic             high_preset_hit_flag_o,
    input logic             irq_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_force;
        acc_write_instr_i && acc_write_val_i == `ACC_ONE ##1 clear_instr_i
        && acc_o == `ACC_ONE && low_preset_i == `ACC_ZERO;
    endsequence
    a_forced_low_irq: assert property (
        s_force |=> low_preset_hit_flag_o ##1 irq_o)
        else $error("forced low interrupt missing");
    a_clear_zero_acc: assert property (clear_instr_i |=> acc_o == `ACC_ZERO)
        else $error("clear did not zero");
    a_low_flag_cause: assert property ($rose(low_preset_hit_flag_o) |->
        acc_o == low_preset_i && acc_o != $past(acc_o))
        else $error("bad low flag");
    a_high_flag_cause: assert property ($rose(high_preset_hit_flag_o) |->
        acc_o == high_preset_i && acc_o != $past(acc_o))
        else $error("bad high flag");
    a_irq_after_flag: assert property ($rose(low_preset_hit_flag_o ||
        high_preset_hit_flag_o) |=> irq_o)
        else $error("interrupt missing");
    a_ack_clears_low: assert property (ack_low_i ##1 acc_o == $past(acc_o)
        |-> !low_preset_hit_flag_o)
        else $error("ack did not clear");
    a_ack_clears_high: assert property (ack_high_i ##1
        acc_o == $past(acc_o) |-> !high_preset_hit_flag_o)
        else $error("ack did not clear high flag");
    a_run_entry_off: assert property (run_entry_i |=> !enabled_o)
        else $error("still enabled");
    a_enable_turns_on: assert property (enable_instr_i && !run_entry_i
        |=> enabled_o)
        else $error("not enabled");
endmodule // qpc_checker
bind quadrature_preset_counter qpc_checker u_chk (
    .core_clk_i             (core_clk_i),
    .rst_i                  (rst_i),
    .run_entry_i            (run_entry_i),
    .enable_instr_i         (enable_instr_i),
    .clear_instr_i          (clear_instr_i),
    .acc_write_instr_i      (acc_write_instr_i),
    .ack_low_i              (ack_low_i),
    .ack_high_i             (ack_high_i),
    .acc_write_val_i        (acc_write_val_i),
    .low_preset_i           (low_preset_i),
    .high_preset_i          (high_preset_i),
    .acc_o                  (acc_o),
    .enabled_o              (enabled_o),
    .low_preset_hit_flag_o  (low_preset_hit_flag_o),
    .high_preset_hit_flag_o (high_preset_hit_flag_o),
    .irq_o                  (irq_o)
);

// ### dv/tb.sv
`include "quad_counter_consts.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [6:0] cmd = 7'h00;
    logic [`ACC_W-1:0] wv = 16'h0001, hp = 16'h0003, lp = 16'h0000;
    logic [`OUT_W-1:0] msk = 16'h0007, hpt = 16'h0002, lpt = 16'h0005;
    logic [`OUT_W-1:0] pout = 16'h00F0;
    logic [`FILT_W-1:0] filt = 8'h00;
    logic hold_x = 1'b0;
    wire enc_a, enc_b, sw, en, lf, hf, irq;
    wire [`ACC_W-1:0] acc;
    wire [`OUT_W-1:0] out;
    int miscompares = 0;
    int n_tests = 0;
    always #4 core_clk_i = ~core_clk_i;
    quad_encoder_model ENC (.core_clk_i(core_clk_i), .enc_a_o(enc_a),
        .enc_b_o(enc_b), .sw_o(sw));
    quadrature_preset_counter #(.TICK_CYC(2)) DUT (.core_clk_i(core_clk_i),
        .rst_i(rst_i), .enc_a_i(enc_a), .enc_b_i(enc_b), .ext_reset_i(sw),
        .ext_hold_i(sw | hold_x), .filt_a_i(filt), .filt_b_i(filt),
        .filt_rst_i(filt), .filt_hold_i(filt),
        .run_entry_i(cmd[6]), .enable_instr_i(cmd[5]),
        .load_outputs_instr_i(cmd[4]), .clear_instr_i(cmd[3]),
        .acc_write_instr_i(cmd[2]), .acc_write_val_i(wv),
        .ack_low_i(cmd[1]), .ack_high_i(cmd[0]), .high_preset_i(hp),
        .low_preset_i(lp), .out_mask_i(msk), .high_pattern_i(hpt),
        .low_pattern_i(lpt), .prog_out_i(pout), .acc_o(acc),
        .enabled_o(en), .low_preset_hit_flag_o(lf),
        .high_preset_hit_flag_o(hf), .irq_o(irq), .out_o(out));
    task report_and_stop;
        if (miscompares == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Two command words on consecutive cycles, then idle.
    task pulse(input logic [6:0] c, input logic [6:0] d);
        @(posedge core_clk_i);
        #1 cmd = c;
        @(posedge core_clk_i);
        #1 cmd = d;
        @(posedge core_clk_i);
        #1 cmd = 7'h00;
        repeat (4) @(posedge core_clk_i);
        #1;
    endtask
    initial
    begin
        repeat (8) @(posedge core_clk_i);
        #1 rst_i = 1'b0;
        ENC.step(1'b1);
        chk(acc, 16'h0000);
        chk(en, 1'b0);
        pulse(7'h50, 7'h20);
        pulse(7'h04, 7'h08);
        chk(acc, 16'h0000);
        chk(lf, 1'b1);
        chk(irq, 1'b1);
        chk(out, 16'h00F5);
        pulse(7'h02, 7'h00);
        chk(lf, 1'b0);
        for (int i = 1; i <= 3; i++)
        begin
            ENC.step(1'b1);
            chk(acc, i[15:0]);
        end
        chk(hf, 1'b1);
        chk(out, 16'h00F2);
        ENC.step(1'b0);
        chk(acc, 16'h0002);
        pulse(7'h01, 7'h00);
        chk(hf, 1'b0);
        ENC.set_sw(1'b1);
        chk(acc, 16'h0000);
        chk(lf, 1'b1);
        ENC.step(1'b1);
        chk(acc, 16'h0000);
        ENC.set_sw(1'b0);
        ENC.step(1'b1);
        chk(acc, 16'h0001);
        // Hold alone, with the reset line low, must freeze the count.
        hold_x = 1'b1;
        ENC.step(1'b1);
        chk(acc, 16'h0001);
        hold_x = 1'b0;
        repeat (2) @(posedge core_clk_i);
        #1 filt = 8'h08;
        // A long filter delay keeps the edge away for about 16 cycles.
        ENC.step(1'b1);
        chk(acc, 16'h0001);
        repeat (12) @(posedge core_clk_i);
        #1 filt = `FILT_ZERO;
        chk(acc, 16'h0002);
        pulse(7'h40, 7'h00);
        ENC.step(1'b1);
        chk(acc, 16'h0002);
        // A preset moved onto the resting count must not raise a flag.
        hp = 16'h0002;
        pout = 16'h0A00;
        repeat (2) @(posedge core_clk_i);
        #1 chk(hf, 1'b0);
        chk(out, 16'h0A05);
        report_and_stop;
    end
    initial
    begin
        #100000;
        miscompares++;
        report_and_stop;
    end
endmodule // tb
